// [hw/qdac_ctrl.sv]
// Quad converter control behind a two-wire serial slave interface
`timescale 1ns/10ps
// Summary of operation
// - Address low bit follows the address-select input level.
// - Per channel an input and a converter register; loads may skip output.
// - Channel codes are 10-bit straight binary, 0 to 1023.
// - Reset clears converter registers and selects 100k power-down.
// - Select 00 up, 01 float, 10 one-k, 11 hundred-k termination.
// - Registers keep contents in power-down; wake restores prior output.
// - Slave only; master makes the serial clock and starts transfers.
// - START framed, STOP ended, 8-bit bytes each with acknowledge slot.
// - Data line driven open drain: pull low or release.
// - One bit per clock; data changes only while clock is low.
// - Data falling with clock high is START, rising is STOP.
// - Repeated START keeps bus busy and expects a new address.
// - After STOP or foreign address, clock ignored until next START.
// - Idle bus lines rest high with nobody pulling low.
// - Address last bit: 0 writes to device, 1 reads from it.
// - Registers update at falling clock of acknowledge; aborts discarded.
// - Command nibble ones with top data zero selects extended byte.
// - General call and ten-bit addressing are not recognised.
module qdac_ctrl
    import qdac_pkg::*;
#(
    parameter logic [5:0] ADDR_HI = 6'h1E
) (
    input  wire logic                  clock,
    input  wire logic                  arst_n,
    input  wire logic                  sclClk,
    input  wire logic                  sdaIn,
    output logic                       sdaOut,
    output logic                       sdaOe,
    input  wire logic                  addrSel,
    output qdac_pkg::qdac_out_type     chanAOut,
    output qdac_pkg::qdac_out_type     chanBOut,
    output qdac_pkg::qdac_out_type     chanCOut,
    output qdac_pkg::qdac_out_type     chanDOut
);
    import qdac_pkg::*;

    // Bus events must be seen well inside one serial half period; an
    // all-zero address would answer the general call
    if (SCL_HALF_CYC <= CROSS_CYC || ADDR_HI == 6'h00) begin : g_bad_cfg
        $error("unsupported clock ratio or slave address");
    end

    qdac_state_type    state_q;
    logic [2:0]        pinSync;
    logic              sclS;
    logic              sdaS;
    logic              addrSelS;
    logic              sclPrev_q;
    logic              sdaPrev_q;
    logic              bitVal;
    logic              bitTgl;
    logic              tglSync;
    logic              tglPrev_q;
    logic              sleep_q;
    logic              startEv;
    logic              stopEv;
    logic              bitEv;
    logic              fallEv;
    logic [7:0]        shift_q;
    logic [3:0]        bitCnt_q;
    logic              rw_q;
    logic              byteSel_q;
    logic [7:0]        cmd_q;
    logic [7:0]        data_q;
    logic              commitEv;
    logic [7:0]        tx_q;
    logic              rdByte_q;
    logic [1:0]        rdChan_q;
    logic              nack_q;
    logic [CODE_W-1:0] input_q [CHANS];
    logic [CODE_W-1:0] dac_q   [CHANS];
    logic [1:0]        pd_q    [CHANS];
    logic [CODE_W-1:0] newCode;
    logic [3:0]        cmdNib;
    logic              extCmd;
    logic              sdaOe_q;
    logic              afterAddr_q;
    logic [6:0]        ownAddr;

    // Pins cross from outside: bus lines and address strap
    qdac_sync #(.WIDTH(3)) u_pinSync (
        .clock   (clock),
        .arst_n  (arst_n),
        .asyncIn ({sclClk, sdaIn, addrSel}),
        .syncOut (pinSync)
    );
    assign sclS     = pinSync[2];
    assign sdaS     = pinSync[1];
    assign addrSelS = pinSync[0];
    // Own seven-bit address; the strap sets its low bit
    assign ownAddr  = {ADDR_HI, addrSelS};

    // Bits are taken on the real rising serial edge, then handed over
    qdac_bit_capture u_capture (
        .sclClk   (sclClk),
        .arst_n   (arst_n),
        .sdaIn    (sdaIn),
        .bitVal_q (bitVal),
        .bitTgl_q (bitTgl)
    );

    // Toggle crossing; the captured bit is stable a whole bus clock
    qdac_sync #(.WIDTH(1)) u_tglSync (
        .clock   (clock),
        .arst_n  (arst_n),
        .asyncIn (bitTgl),
        .syncOut (tglSync)
    );

    // Previous samples for edge and condition detection
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
            tglPrev_q <= 1'b1;
        end else begin
            sclPrev_q <= sclS;
            sdaPrev_q <= sdaS;
            tglPrev_q <= tglSync;
        end
    end

    // Conditions seen with the clock high; the block gate hides the rest
    assign startEv = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
    assign stopEv  = sclS & sclPrev_q & ~sdaPrev_q & sdaS;
    assign bitEv   = (tglSync ^ tglPrev_q) & ~sleep_q;
    assign fallEv  = sclPrev_q & ~sclS & ~sleep_q;

    // Command decode for the pending write pair
    assign cmdNib  = cmd_q[7:4];
    assign extCmd  = (cmdNib == CMD_EXT) && (cmd_q[3:0] == 4'h0);
    assign newCode = {cmd_q[3:0], data_q[7:2]};
    // Update lands on the fall that ends the data byte's ack slot
    assign commitEv = fallEv && (state_q == ST_ACKOUT) && !rw_q
                      && byteSel_q && (bitCnt_q == BYTE_BITS);

    // Serial clock gate: closed by STOP or foreign address, opened by START
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sleep_q <= 1'b1;
        end else if (startEv) begin
            sleep_q <= 1'b0;
        end else if (stopEv) begin
            sleep_q <= 1'b1;
        end else if (state_q == ST_ADDR && bitEv && bitCnt_q < 4'h7) begin
            if (bitVal != ownAddr[3'h6 - bitCnt_q[2:0]]) begin
                sleep_q <= 1'b1;
            end
        end
    end

    // Protocol sequencer; only the master's START opens a transfer
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q   <= ST_IDLE;
            bitCnt_q  <= 4'h0;
            shift_q   <= 8'h00;
            rw_q      <= 1'b0;
            byteSel_q <= 1'b0;
            nack_q    <= 1'b0;
            afterAddr_q <= 1'b0;
        end else if (startEv) begin
            state_q   <= ST_ADDR;
            afterAddr_q <= 1'b1;
            bitCnt_q  <= 4'h0;
            byteSel_q <= 1'b0;
        end else if (stopEv) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    bitCnt_q <= 4'h0;
                end
                ST_ADDR, ST_WBYTE: begin
                    if (bitEv) begin
                        shift_q  <= {shift_q[6:0], bitVal};
                        bitCnt_q <= bitCnt_q + 4'h1;
                        if (state_q == ST_ADDR && bitCnt_q < 4'h7 &&
                            bitVal != ownAddr[3'h6 - bitCnt_q[2:0]])
                        begin
                            state_q <= ST_IDLE;
                        end
                        if (state_q == ST_ADDR && bitCnt_q == 4'h7) begin
                            rw_q <= bitVal;
                        end
                    end else if (fallEv && bitCnt_q == BYTE_BITS) begin
                        state_q <= ST_ACKOUT;
                    end
                end
                ST_ACKOUT: begin
                    if (fallEv) begin
                        bitCnt_q    <= 4'h0;
                        afterAddr_q <= 1'b0;
                        if (rw_q == RW_READ) begin
                            state_q <= ST_RBYTE;
                        end else begin
                            state_q <= ST_WBYTE;
                            // Address ack leads to a command byte
                            if (!afterAddr_q) begin
                                byteSel_q <= ~byteSel_q;
                            end
                        end
                    end
                end
                ST_RBYTE: begin
                    if (bitEv) begin
                        bitCnt_q <= bitCnt_q + 4'h1;
                    end else if (fallEv && bitCnt_q == BYTE_BITS) begin
                        state_q <= ST_ACKIN;
                    end
                end
                ST_ACKIN: begin
                    if (bitEv) begin
                        nack_q <= bitVal;
                    end else if (fallEv) begin
                        bitCnt_q <= 4'h0;
                        // Not-acknowledge: stay released until STOP
                        state_q  <= nack_q ? ST_IDLE : ST_RBYTE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Latch the command and data bytes at the end of each received byte
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cmd_q    <= 8'h00;
            data_q   <= 8'h00;
            rdChan_q <= 2'h0;
        end else if (state_q == ST_WBYTE && fallEv &&
                     bitCnt_q == BYTE_BITS) begin
            if (byteSel_q) begin
                data_q <= shift_q;
            end else begin
                cmd_q    <= shift_q;
                rdChan_q <= shift_q[5:4];
            end
        end
    end

    // Read-back: channel then upper code bits, then low code bits
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tx_q     <= 8'h00;
            rdByte_q <= 1'b0;
        end else if (startEv) begin
            rdByte_q <= 1'b0;
        end else if (fallEv && ((state_q == ST_ACKOUT && rw_q) ||
                                (state_q == ST_ACKIN && !nack_q))) begin
            rdByte_q <= ~rdByte_q;
            if (!rdByte_q) begin
                tx_q <= {2'h0, rdChan_q, dac_q[rdChan_q][9:6]};
            end else begin
                tx_q <= {dac_q[rdChan_q][5:0], 2'h0};
            end
        end else if (fallEv && state_q == ST_RBYTE) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // Data line drive, changed after a serial falling edge; START and STOP release it
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sdaOe_q <= 1'b0;
        end else if (startEv || stopEv) begin
            sdaOe_q <= 1'b0;
        end else if (fallEv) begin
            unique case (state_q)
                ST_ADDR, ST_WBYTE: begin
                    // Pull low for the acknowledge slot
                    sdaOe_q <= (bitCnt_q == BYTE_BITS);
                end
                ST_ACKOUT: begin
                    // Read starts with the first data bit on this fall
                    sdaOe_q <= (rw_q == RW_READ);
                end
                ST_RBYTE: begin
                    sdaOe_q <= (bitCnt_q != BYTE_BITS) && !tx_q[6];
                end
                ST_ACKIN: begin
                    // Byte two opens with code bit 5, byte one with zero
                    sdaOe_q <= !nack_q && !(rdByte_q && dac_q[rdChan_q][5]);
                end
                default: begin
                    sdaOe_q <= 1'b0;
                end
            endcase
        end
    end

    // Open drain: the driven level is always low
    assign sdaOut = 1'b0;
    assign sdaOe  = sdaOe_q;

    // Per-channel input, converter and power-down registers
    for (genvar ch = 0; ch < CHANS; ch++) begin : g_chan
        always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                input_q[ch] <= CODE_RESET;
                dac_q[ch]   <= CODE_RESET;
                pd_q[ch]    <= PD_RESET;
            end else if (commitEv) begin
                if (extCmd) begin
                    // Wake restores the held code, nothing is rewritten
                    if (data_q[EXT_CHAN_LSB + ch]) begin
                        pd_q[ch] <= {data_q[EXT_SEL_HI],
                                     data_q[EXT_SEL_LO]};
                    end
                end else if (cmdNib[1:0] == 2'(ch) &&
                             cmdNib[3:2] != 2'h3) begin
                    input_q[ch] <= newCode;
                    if (cmdNib[3:2] != GRP_LOAD_IN) begin
                        dac_q[ch] <= newCode;
                    end
                end else if (cmdNib[3:2] == GRP_LOAD_UPD ||
                             cmdNib == CMD_UPD_ALL) begin
                    dac_q[ch] <= input_q[ch];
                end
            end
        end
    end

    // Outputs show the held code; the select says whether it is driven
    assign chanAOut = '{pwrdnSel: pd_q[0], code: dac_q[0]};
    assign chanBOut = '{pwrdnSel: pd_q[1], code: dac_q[1]};
    assign chanCOut = '{pwrdnSel: pd_q[2], code: dac_q[2]};
    assign chanDOut = '{pwrdnSel: pd_q[3], code: dac_q[3]};

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    chk_idle_released: assert property (
        (state_q == ST_IDLE && $past(state_q) == ST_IDLE) |-> !sdaOe)
        else $error("data line pulled while idle");
    chk_stop_blocks: assert property (
        (stopEv && !startEv) |=> (sleep_q && state_q == ST_IDLE))
        else $error("stop did not block the serial clock");
    chk_start_addr: assert property (
        startEv |=> (!sleep_q && state_q == ST_ADDR && bitCnt_q == 4'h0))
        else $error("start did not open address phase");
    chk_mismatch_nack: assert property (
        (state_q == ST_ADDR && bitEv && !startEv && !stopEv &&
         bitCnt_q < 4'h7 &&
         bitVal != ownAddr[3'h6 - bitCnt_q[2:0]])
        |=> (state_q == ST_IDLE && sleep_q) ##1 !sdaOe[*3])
        else $error("foreign address not dropped");
    chk_dac_on_commit: assert property (
        ($changed(dac_q[0]) || $changed(dac_q[1])) |-> $past(commitEv))
        else $error("converter register changed outside ack fall");
    chk_pd_ext_only: assert property (
        $changed(pd_q[2]) |-> $past(commitEv && extCmd))
        else $error("power-down changed without extended byte");
    chk_ackin_release: assert property (
        (state_q == ST_ACKIN && $past(state_q) == ST_ACKIN) |-> !sdaOe)
        else $error("device drove line in master ack slot");
    chk_ack_low: assert property (
        (fallEv && state_q == ST_WBYTE && bitCnt_q == BYTE_BITS &&
         !startEv && !stopEv) |=> (sdaOe && state_q == ST_ACKOUT))
        else $error("received byte not acknowledged");
endmodule // qdac_ctrl

// [hw/qdac_pkg.sv]
// Shared constants and types for the quad converter serial slave control
package qdac_pkg;
    // Channel data and bus framing
    localparam int          CODE_W      = 10;
    localparam int          CHANS       = 4;
    localparam logic [3:0]  BYTE_BITS   = 4'h8;
    localparam logic [9:0]  CODE_RESET  = 10'h000;
    localparam logic        RW_READ     = 1'b1;
    // Power-down select codes {pwrdn_sel_hi, pwrdn_sel_lo}
    localparam logic [1:0]  PD_UP       = 2'h0;
    localparam logic [1:0]  PD_FLOAT    = 2'h1;
    localparam logic [1:0]  PD_1K       = 2'h2;
    localparam logic [1:0]  PD_100K     = 2'h3;
    localparam logic [1:0]  PD_RESET    = PD_100K;
    // Command nibble decode
    localparam logic [3:0]  CMD_EXT     = 4'hF;
    localparam logic [3:0]  CMD_UPD_ALL = 4'hC;
    localparam logic [1:0]  GRP_LOAD_UPD = 2'h0;
    localparam logic [1:0]  GRP_LOAD_IN  = 2'h1;
    localparam logic [1:0]  GRP_LOAD_OWN = 2'h2;
    // Extended byte fields
    localparam int          EXT_CHAN_LSB = 4;
    localparam int          EXT_SEL_HI   = 1;
    localparam int          EXT_SEL_LO   = 0;
    // Timing: serial clock half period against the system clock
    localparam int          CLK_PERIOD_NS = 100;
    localparam int          FSCL_MAX_KHZ  = 400;
    localparam int          SCL_HALF_NS   = 1000000 / (2 * FSCL_MAX_KHZ);
    localparam int          SCL_HALF_CYC  = SCL_HALF_NS / CLK_PERIOD_NS;
    localparam int          CROSS_CYC     = 4;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_ADDR   = 3'h1,
        ST_WBYTE  = 3'h2,
        ST_RBYTE  = 3'h3,
        ST_ACKOUT = 3'h4,
        ST_ACKIN  = 3'h5
    } qdac_state_type;

    typedef struct packed {
        logic [1:0]        pwrdnSel;
        logic [CODE_W-1:0] code;
    } qdac_out_type;
endpackage

// [hw/qdac_sync.sv]
// Two-stage level synchroniser into the system clock
`timescale 1ns/10ps
module qdac_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta_q  <= '1;
            syncOut <= '1;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule // qdac_sync

// [hw/qdac_bit_capture.sv]
// Serial clock domain: samples the data line on each rising serial edge
`timescale 1ns/10ps
module qdac_bit_capture (
    input  wire logic sclClk,
    input  wire logic arst_n,
    input  wire logic sdaIn,
    output logic      bitVal_q,
    output logic      bitTgl_q
);
    // Data held a full bus clock, toggle marks each new bit
    always_ff @(posedge sclClk or negedge arst_n) begin
        if (!arst_n) begin
            bitVal_q <= 1'b0;
            // Matches the synchroniser's reset level: no false bit
            bitTgl_q <= 1'b1;
        end else begin
            bitVal_q <= sdaIn;
            bitTgl_q <= ~bitTgl_q;
        end
    end
endmodule // qdac_bit_capture

// [tb/qdac_master_model.sv]
// Bus master model: makes the serial clock and frames every transfer
`timescale 1ns/10ps
module qdac_master_model #(
    parameter int HALF = 14
) (
    input  wire logic clock,
    input  wire logic sdaBus,
    output logic      sclClk,
    output logic      sdaPull
);
    // Both lines released and clock high while the bus rests
    initial begin
        sclClk  = 1'b1;
        sdaPull = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    // One bit per clock; data moves only while the clock is low
    task automatic bitIo(input logic b, output logic r);
        sdaPull <= ~b;
        tick(HALF / 2);
        sclClk <= 1'b1;
        tick(HALF / 2);
        r = sdaBus;
        tick(HALF / 2);
        sclClk <= 1'b0;
        tick(HALF / 2);
    endtask
    // Start or repeated start: data falls while the clock is high
    task automatic busStart();
        if (sclClk === 1'b0) begin
            sdaPull <= 1'b0;
            tick(HALF / 2);
            sclClk <= 1'b1;
            tick(HALF / 2);
        end
        sdaPull <= 1'b1;
        tick(HALF / 2);
        sclClk <= 1'b0;
        tick(HALF / 2);
    endtask
    // Stop: data rises while the clock is high, then the bus is free
    task automatic busStop();
        sdaPull <= 1'b1;
        tick(HALF / 2);
        sclClk <= 1'b1;
        tick(HALF / 2);
        sdaPull <= 1'b0;
        tick(HALF);
    endtask
    // Eight bits MSB first, then the acknowledge slot left released
    task automatic wrByte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitIo(v[i], r);
        bitIo(1'b1, r);
        ack = ~r;
    endtask
    // Receive a byte; the last one is answered with not-acknowledge
    task automatic rdByte(input logic nack, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitIo(1'b1, v[i]);
        bitIo(nack, r);
    endtask
endmodule // qdac_master_model

// [tb/qdac_ctrl_tb_top.sv]
// Self-checking bench for the quad converter serial slave control
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t act=%0h exp=%0h", $time, (a), (e)); end end
module qdac_ctrl_tb_top;
    import qdac_pkg::*;
    localparam logic [5:0] ADR = 6'h1E;
    logic         clock;
    logic         arst_n;
    logic         addrSel;
    wire logic    sclClk;
    wire logic    sdaPull;
    wire logic    sdaBus;
    logic         sdaOut;
    logic         sdaOe;
    qdac_out_type outs [4];
    int           error_cnt;
    int           checked;
    logic         ack;
    logic [7:0]   rb;

    // Pull-up on the data line; any party may only pull it low
    assign sdaBus = ~((sdaOe & ~sdaOut) | sdaPull);

    qdac_ctrl #(.ADDR_HI(ADR)) qdac_ctrl_inst (
        .clock(clock), .arst_n(arst_n), .sclClk(sclClk), .sdaIn(sdaBus),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSel(addrSel),
        .chanAOut(outs[0]), .chanBOut(outs[1]), .chanCOut(outs[2]),
        .chanDOut(outs[3])
    );
    qdac_master_model qdac_master_model_inst (
        .clock(clock), .sdaBus(sdaBus), .sclClk(sclClk), .sdaPull(sdaPull)
    );

    // System clock at 10 MHz
    initial clock = 1'b0;
    always #50 clock = ~clock;

    task automatic complete_run();
        $display("errors=%0d checks=%0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    // One framed write: address, command byte, data byte
    task automatic xfer(input logic [7:0] c, input logic [7:0] d);
        qdac_master_model_inst.busStart();
        qdac_master_model_inst.wrByte({ADR, addrSel, ~RW_READ}, ack);
        `CHK(ack, 1'b1)
        qdac_master_model_inst.wrByte(c, ack);
        `CHK(ack, 1'b1)
        qdac_master_model_inst.wrByte(d, ack);
        `CHK(ack, 1'b1)
        qdac_master_model_inst.busStop();
        cyc(8);
    endtask
    task automatic wrCode(input logic [3:0] n, input logic [9:0] c);
        xfer({n, c[9:6]}, {c[5:0], 2'h0});
    endtask
    task automatic pdSet(input logic [3:0] ch, input logic [1:0] m);
        xfer({CMD_EXT, 4'h0}, {ch, 2'h0, m});
    endtask

    // Reset state, wake-up and every power-down select code
    task automatic scen_power();
        for (int i = 0; i < 4; i++)
            `CHK(outs[i], {PD_RESET, CODE_RESET})
        `CHK(sdaBus, 1'b1)
        pdSet(4'hF, PD_UP);
        for (int i = 0; i < 4; i++)
            `CHK(outs[i], {PD_UP, CODE_RESET})
        for (int m = 1; m < 4; m++) begin
            pdSet(4'h1, m[1:0]);
            `CHK(outs[0].pwrdnSel, m[1:0])
            `CHK(outs[1].pwrdnSel, PD_UP)
        end
        pdSet(4'h1, PD_UP);
    endtask
    // Input-only load, single-channel load, move-all and load-and-move
    task automatic scen_loads();
        wrCode(4'h4, 10'h3FF);
        `CHK(outs[0].code, 10'h000)
        wrCode(4'h9, 10'h155);
        `CHK(outs[1].code, 10'h155)
        `CHK(outs[0].code, 10'h000)
        wrCode(CMD_UPD_ALL, 10'h000);
        `CHK(outs[0].code, 10'h3FF)
        wrCode(4'h2, 10'h2AA);
        `CHK(outs[2].code, 10'h2AA)
        `CHK(outs[3].code, 10'h000)
    endtask
    // Codes survive power-down and come back on wake
    task automatic scen_retain();
        pdSet(4'h1, PD_1K);
        `CHK(outs[0], {PD_1K, 10'h3FF})
        pdSet(4'h1, PD_UP);
        `CHK(outs[0], {PD_UP, 10'h3FF})
    endtask
    // Foreign address, general call, then the other strap level
    task automatic scen_addr();
        qdac_master_model_inst.busStart();
        qdac_master_model_inst.wrByte({ADR, ~addrSel, 1'b0}, ack);
        `CHK(ack, 1'b0)
        // A pair that would load channel A with a new code if heard
        qdac_master_model_inst.wrByte(8'h82, ack);
        `CHK(ack, 1'b0)
        qdac_master_model_inst.wrByte(8'hFC, ack);
        qdac_master_model_inst.busStop();
        `CHK(outs[0].code, 10'h3FF)
        qdac_master_model_inst.busStart();
        qdac_master_model_inst.wrByte(8'h00, ack);
        `CHK(ack, 1'b0)
        qdac_master_model_inst.busStop();
        addrSel <= 1'b0;
        cyc(6);
        wrCode(4'h8, 10'h001);
        `CHK(outs[0].code, 10'h001)
        addrSel <= 1'b1;
        cyc(6);
    endtask
    // Lone command aborted by stop, then by a repeated start
    task automatic scen_frame();
        qdac_master_model_inst.busStart();
        qdac_master_model_inst.wrByte({ADR, addrSel, 1'b0}, ack);
        qdac_master_model_inst.wrByte(8'h8F, ack);
        qdac_master_model_inst.busStop();
        `CHK(outs[0].code, 10'h001)
        qdac_master_model_inst.busStart();
        qdac_master_model_inst.wrByte({ADR, addrSel, 1'b0}, ack);
        qdac_master_model_inst.wrByte(8'h8F, ack);
        xfer(8'hBF, 8'h00);
        `CHK(outs[3].code, 10'h3C0)
        `CHK(outs[0].code, 10'h001)
    endtask
    // Read back channel D after a fresh load; not-acknowledge then stop
    task automatic scen_read();
        wrCode(4'hB, 10'h2A5);
        `CHK(outs[3].code, 10'h2A5)
        qdac_master_model_inst.busStart();
        qdac_master_model_inst.wrByte({ADR, addrSel, RW_READ}, ack);
        `CHK(ack, 1'b1)
        // Byte one: zeros, channel, upper code bits
        qdac_master_model_inst.rdByte(1'b0, rb);
        `CHK(rb, 8'h3A)
        // Byte two: low code bits, then two zeros
        qdac_master_model_inst.rdByte(1'b1, rb);
        `CHK(rb, 8'h94)
        qdac_master_model_inst.busStop();
        `CHK(sdaBus, 1'b1)
        `CHK(sdaOut, 1'b0)
    endtask

    // Hang guard: a run that outlives this bound is a failure
    initial begin
        cyc(90000);
        error_cnt++;
        complete_run();
    end
    // Reset for 20 cycles, then the scenarios in order
    initial begin
        arst_n    = 1'b0;
        addrSel   = 1'b1;
        error_cnt = 0;
        checked   = 0;
        cyc(20);
        arst_n <= 1'b1;
        cyc(5);
        scen_power();
        scen_loads();
        scen_retain();
        scen_addr();
        scen_frame();
        scen_read();
        complete_run();
    end
endmodule // qdac_ctrl_tb_top
